// file: common/gpc_defines.vh
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
// Bus command codes (ATN true, low seven bits)
`define GPC_CMD_UNL 7'h3f
`define GPC_CMD_UNT 7'h5f
`define GPC_CMD_SPE 7'h18
`define GPC_CMD_SPD 7'h19
`define GPC_CMD_DCL 7'h14
`define GPC_CMD_SDC 7'h04
`define GPC_CMD_GTL 7'h01
`define GPC_CMD_LLO 7'h11
// Address groups: bits 6..5 select listen or talk group
`define GPC_GRP_LISTEN 2'h1
`define GPC_GRP_TALK 2'h2
// Program code letters and their latch addresses
`define GPC_CODE_FIRST 7'h4b
`define GPC_CODE_LAST 7'h5a
`define GPC_LATCH_AM 4'h2
`define GPC_LATCH_FM 4'h3
`define GPC_LATCH_FREQ 4'h5
// Argument characters are ASCII 0x30..0x3f
`define GPC_ARG_LO 7'h30
`define GPC_ARG_HI 7'h3f
`define GPC_LATCH_CNT 16
`define GPC_FREQ_DIGITS 9
// Status byte returned during serial poll
`define GPC_STB_RESET 8'h00
`endif

// file: design/gpc_buf2.v
`timescale 1ns/1ns
// Two-entry buffer between handshake front end and parser
module gpc_buf2 (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [7:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data
);

reg [7:0] mem_r [0:1];
reg wr_ptr_r;
reg rd_ptr_r;
reg [1:0] cnt_r;

assign in_ready = (cnt_r != 2'h2);
assign out_valid = (cnt_r != 2'h0);
assign out_data = mem_r[rd_ptr_r];

// ----------------------------------------
// Storage and pointers
// ----------------------------------------
// Order is kept: one write and one read pointer, strictly FIFO
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        mem_r[0] <= 8'h00;
        mem_r[1] <= 8'h00;
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
        cnt_r <= 2'h0;
    end else begin
        if (in_valid && in_ready) begin
            mem_r[wr_ptr_r] <= in_data;
            wr_ptr_r <= ~wr_ptr_r;
        end
        if (out_valid && out_ready)
            rd_ptr_r <= ~rd_ptr_r;
        case ({in_valid && in_ready, out_valid && out_ready})
            2'b10: cnt_r <= cnt_r + 2'h1;
            2'b01: cnt_r <= cnt_r - 2'h1;
            default: cnt_r <= cnt_r;
        endcase
    end
end

endmodule // gpc_buf2

// file: design/gpc_parser.v
`timescale 1ns/1ns
`include "gpc_defines.vh"
// Contract
// - Characters are taken only through the three-wire handshake.
// - The ATN management line separates data from address and command characters; the character value tells address from command.
// - Matching talk or listen address enters talker or listener state.
// - Bus commands such as serial poll enable are decoded and executed.
// - Data goes to the parser only while addressed to listen.
// - Each program code maps to one latch holding one function setting.
// - Characters of a string are processed strictly in arrival order.
// - Latch address increments after each stored argument, except the first nine digits at the frequency latch.
// - A new program code reloads the latch address.
// - Amplitude and frequency modulation codes are recognised.
// - Local-to-remote transition captures front-panel settings.
// - Remote frequency digits load straight into the first frequency register.
module gpc_parser (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Bus data and handshake (active low pins)
    input wire [7:0] dio_n_i,
    output wire [7:0] dio_n_o,
    output wire [7:0] dio_n_oe,
    input wire dav_n_i,
    output wire dav_n_o,
    output wire dav_n_oe,
    input wire nrfd_n_i,
    output wire nrfd_n_o,
    output wire nrfd_n_oe,
    input wire ndac_n_i,
    output wire ndac_n_o,
    output wire ndac_n_oe,
    // Bus management lines
    input wire atn_n_i,
    input wire ifc_n_i,
    input wire ren_n_i,
    input wire eoi_n_i,
    output wire srq_n_o,
    output wire srq_n_oe,
    // Instrument configuration
    input wire [4:0] bus_addr,
    input wire [7:0] status_byte,
    input wire service_req,
    // Front-panel settings for local-to-remote capture
    input wire [63:0] panel_settings,
    // Selector latches and strobes
    output reg [63:0] latch_data_r,
    output reg [15:0] latch_strobe_r,
    output reg remote_amplitude_mod_strobe,
    output reg remote_frequency_mod_strobe,
    output reg parser_cycle_trigger,
    output reg [35:0] freq_reg1_r,
    // State indicators
    output reg remote_r,
    output reg talker_r,
    output reg listener_r,
    output reg clear_pulse_r
);

// ----------------------------------------
// Synchronisers and helpers
// ----------------------------------------
reg [7:0] dio_s1_r, dio_s2_r;
reg [4:0] ctl_s1_r, ctl_s2_r;
reg [1:0] hs_s1_r, hs_s2_r;
reg remote_nxt;

// Pins are asynchronous to mclk; two stages before any use
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        dio_s1_r <= 8'h00;
        dio_s2_r <= 8'h00;
        ctl_s1_r <= 5'h00;
        ctl_s2_r <= 5'h00;
        hs_s1_r <= 2'h0;
        hs_s2_r <= 2'h0;
    end else begin
        dio_s1_r <= ~dio_n_i;
        dio_s2_r <= dio_s1_r;
        ctl_s1_r <= {~atn_n_i, ~ifc_n_i, ~ren_n_i, ~eoi_n_i, 1'b0};
        ctl_s2_r <= ctl_s1_r;
        hs_s1_r <= {~dav_n_i, ~ndac_n_i};
        hs_s2_r <= hs_s1_r;
    end
end

wire dav = hs_s2_r[1];
wire ndac_act = hs_s2_r[0];
wire atn = ctl_s2_r[4];
wire ifc = ctl_s2_r[3];
wire ren = ctl_s2_r[2];

// Program letter to latch address
function [3:0] code_addr;
    input [6:0] ch;
    reg [6:0] d;
    begin
        d = ch - `GPC_CODE_FIRST;
        code_addr = d[3:0];
    end
endfunction

function is_code;
    input [6:0] ch;
    begin
        is_code = (ch >= `GPC_CODE_FIRST) && (ch <= `GPC_CODE_LAST);
    end
endfunction

// ----------------------------------------
// Acceptor handshake
// ----------------------------------------
localparam AH_IDLE = 2'h0;
localparam AH_TAKE = 2'h1;
localparam AH_WAIT = 2'h2;
reg [1:0] ah_r;
reg accept_r;
reg [7:0] char_r;
reg char_atn_r;
wire buf_in_ready;
reg spoll_r;

// NRFD held while the buffer is full so no word is lost
assign nrfd_n_oe = (ah_r != AH_IDLE) || !buf_in_ready;
assign nrfd_n_o = 1'b0;
assign ndac_n_oe = (ah_r != AH_WAIT);
assign ndac_n_o = 1'b0;
// Talker side only answers serial poll with one byte
reg src_dav_r;
assign dav_n_oe = src_dav_r;
assign dav_n_o = 1'b0;
assign dio_n_oe = src_dav_r ? 8'hff : 8'h00;
assign dio_n_o = ~status_byte;
assign srq_n_oe = service_req && !spoll_r;
assign srq_n_o = 1'b0;

always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        ah_r <= AH_IDLE;
        accept_r <= 1'b0;
        char_r <= 8'h00;
        char_atn_r <= 1'b0;
    end else begin
        accept_r <= 1'b0;
        case (ah_r)
            AH_IDLE: if (dav && buf_in_ready) begin
                ah_r <= AH_TAKE;
            end
            AH_TAKE: begin
                char_r <= dio_s2_r;
                char_atn_r <= atn;
                accept_r <= 1'b1;
                ah_r <= AH_WAIT;
            end
            AH_WAIT: if (!dav) begin
                ah_r <= AH_IDLE;
            end
            default: ah_r <= AH_IDLE;
        endcase
    end
end

// ----------------------------------------
// Address, command and remote control
// ----------------------------------------
wire [6:0] c7 = char_r[6:0];
wire is_lsn = c7[6:5] == `GPC_GRP_LISTEN;
wire is_tlk = c7[6:5] == `GPC_GRP_TALK;
wire data_ok = accept_r && !char_atn_r && listener_r;

// Classification happens on each character accepted with ATN true
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        talker_r <= 1'b0;
        listener_r <= 1'b0;
        spoll_r <= 1'b0;
        clear_pulse_r <= 1'b0;
        src_dav_r <= 1'b0;
    end else begin
        clear_pulse_r <= 1'b0;
        if (ifc) begin
            talker_r <= 1'b0;
            listener_r <= 1'b0;
            spoll_r <= 1'b0;
        end else if (accept_r && char_atn_r) begin
            if (c7 == `GPC_CMD_UNL)
                listener_r <= 1'b0;
            else if (c7 == `GPC_CMD_UNT)
                talker_r <= 1'b0;
            else if (is_lsn && c7[4:0] == bus_addr)
                listener_r <= 1'b1;
            else if (is_tlk)
                talker_r <= (c7[4:0] == bus_addr);
            else if (c7 == `GPC_CMD_SPE)
                spoll_r <= 1'b1;
            else if (c7 == `GPC_CMD_SPD)
                spoll_r <= 1'b0;
            else if (c7 == `GPC_CMD_DCL ||
                     (c7 == `GPC_CMD_SDC && listener_r))
                clear_pulse_r <= 1'b1;
        end
        // Source one status byte while serial polled and talking
        if (!atn && talker_r && spoll_r && !src_dav_r && !ndac_act)
            src_dav_r <= 1'b1;
        else if (src_dav_r && atn)
            src_dav_r <= 1'b0;
    end
end

// Remote latch: GTL to a listener drops remote for one cycle, as listening re-sets it; REN release always does
always @* begin
    remote_nxt = remote_r;
    if (!ren)
        remote_nxt = 1'b0;
    else if (listener_r)
        remote_nxt = 1'b1;
    if (accept_r && char_atn_r && c7 == `GPC_CMD_GTL && listener_r)
        remote_nxt = 1'b0;
end

// ----------------------------------------
// Buffer between bus and program parser
// ----------------------------------------
wire pb_valid;
wire [7:0] pb_data;
gpc_buf2 u_buf (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(data_ok),
    .in_ready(buf_in_ready),
    .in_data(char_r),
    .out_valid(pb_valid),
    .out_ready(1'b1),
    .out_data(pb_data)
);

// ----------------------------------------
// Program parser
// ----------------------------------------
reg [3:0] addr_r;
wire [6:0] p7 = pb_data[6:0];
wire p_arg = (p7 >= `GPC_ARG_LO) && (p7 <= `GPC_ARG_HI);
wire [3:0] p_addr = code_addr(p7);
reg [3:0] freq_cnt_r;

// Buffer drains one char per cycle in order
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        remote_r <= 1'b0;
        addr_r <= 4'h0;
        latch_data_r <= 64'h0;
        latch_strobe_r <= 16'h0000;
        remote_amplitude_mod_strobe <= 1'b0;
        remote_frequency_mod_strobe <= 1'b0;
        parser_cycle_trigger <= 1'b0;
        freq_reg1_r <= 36'h0;
        freq_cnt_r <= 4'h0;
    end else begin
        remote_r <= remote_nxt;
        latch_strobe_r <= 16'h0000;
        remote_amplitude_mod_strobe <= 1'b0;
        remote_frequency_mod_strobe <= 1'b0;
        parser_cycle_trigger <= 1'b0;
        if (remote_nxt && !remote_r)
            latch_data_r <= panel_settings;
        else if (pb_valid) begin
            parser_cycle_trigger <= 1'b1;
            if (is_code(p7)) begin
                addr_r <= p_addr;
                freq_cnt_r <= 4'h0;
            end else if (p_arg) begin
                latch_data_r[addr_r*4 +: 4] <= p7[3:0];
                latch_strobe_r[addr_r] <= 1'b1;
                if (addr_r == `GPC_LATCH_AM)
                    remote_amplitude_mod_strobe <= 1'b1;
                if (addr_r == `GPC_LATCH_FM)
                    remote_frequency_mod_strobe <= 1'b1;
                if (addr_r == `GPC_LATCH_FREQ &&
                    freq_cnt_r < `GPC_FREQ_DIGITS) begin
                    freq_reg1_r <= {freq_reg1_r[31:0], p7[3:0]};
                    freq_cnt_r <= freq_cnt_r + 4'h1;
                end else
                    addr_r <= addr_r + 4'h1;
            end
        end
    end
end

endmodule // gpc_parser

// file: bench/gpc_parser_sva.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the command parser
// ----------------------------------------
module gpc_parser_chk (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Bus side
    input wire dav_n_i,
    input wire ren_n_i,
    input wire nrfd_n_oe,
    input wire ndac_n_oe,
    input wire [7:0] dio_n_oe,
    input wire srq_n_oe,
    // Instrument side
    input wire service_req,
    input wire [63:0] panel_settings,
    input wire [63:0] latch_data_r,
    input wire [15:0] latch_strobe_r,
    input wire remote_amplitude_mod_strobe,
    input wire remote_frequency_mod_strobe,
    input wire remote_r,
    input wire talker_r,
    input wire listener_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Acceptance only while ready is withheld and valid seen earlier
    property p_take;
        $fell(ndac_n_oe) |-> nrfd_n_oe && !$past(dav_n_i, 2);
    endproperty
    a_take: assert property (p_take)
        else $error("ndac released without a valid character");
    property p_onehot;
        (latch_strobe_r != 16'h0000) |-> $onehot(latch_strobe_r);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one latch strobed");
    property p_am;
        remote_amplitude_mod_strobe |-> latch_strobe_r[2];
    endproperty
    a_am: assert property (p_am)
        else $error("am strobe without its latch");
    property p_fm;
        remote_frequency_mod_strobe |-> latch_strobe_r[3];
    endproperty
    a_fm: assert property (p_fm)
        else $error("fm strobe without its latch");
    property p_listen_only;
        (latch_strobe_r != 16'h0000) |-> listener_r;
    endproperty
    a_listen_only: assert property (p_listen_only)
        else $error("latch written while not listener");
    property p_rem_set;
        $rose(remote_r) |-> listener_r && !ren_n_i;
    endproperty
    a_rem_set: assert property (p_rem_set)
        else $error("remote set without enable and listen");
    property p_rem_drop;
        $rose(ren_n_i) |-> ##[1:4] !remote_r;
    endproperty
    a_rem_drop: assert property (p_rem_drop)
        else $error("remote held after enable released");
    property p_capture;
        $rose(remote_r) |-> ##[0:2] (latch_data_r == panel_settings);
    endproperty
    a_capture: assert property (p_capture)
        else $error("panel settings not captured");
    property p_talk_drive;
        (dio_n_oe != 8'h00) |-> talker_r;
    endproperty
    a_talk_drive: assert property (p_talk_drive)
        else $error("data lines driven while not talker");
    property p_srq;
        srq_n_oe |-> service_req || $past(service_req);
    endproperty
    a_srq: assert property (p_srq)
        else $error("service request without cause");
    // Main scenarios reached
    c_remote: cover property ($rose(remote_r));
    c_am: cover property (remote_amplitude_mod_strobe);
    c_talk: cover property ($rose(talker_r));
endmodule // gpc_parser_chk

// file: bench/gpc_ctl_model.sv
`timescale 1ns/1ns
// Bus controller: source side of the three-wire handshake
module gpc_ctl_model (
    // Clock and bus levels seen on the wire
    input wire mclk,
    input wire nrfd_n,
    input wire ndac_n,
    // Lines driven by the controller
    output reg [7:0] dio_n,
    output reg dav_n,
    output reg atn_n
);
    initial begin
        dio_n = 8'hff;
        dav_n = 1'b1;
        atn_n = 1'b1;
    end
    // One character; the ATN level stays as sent, so after a command no talker starts up
    task automatic send(input [7:0] c, input bit atn);
        int n;
        n = 0;
        while (nrfd_n !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        dio_n <= ~c;
        atn_n <= ~atn;
        @(posedge mclk);
        dav_n <= 1'b0;
        while (ndac_n !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        dav_n <= 1'b1;
        dio_n <= 8'hff; // Released lines float to the pull-up
        @(posedge mclk);
        if (n >= 200) begin
            tb_gpc_parser.failures++;
            tb_gpc_parser.stop_test();
        end
    endtask
endmodule // gpc_ctl_model

// file: bench/tb_gpc_parser.sv
`timescale 1ns/1ns
module tb_gpc_parser;
    localparam [4:0] ADDR = 5'h0d;
    localparam [63:0] PANEL = 64'h0123456789abcdef;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ren_n = 1'b1;
    logic service_req = 1'b0;
    logic [63:0] exp_r;
    int failures = 0;
    int check_count = 0;
    wire [7:0] c_dio, dio_oe, dio_w, latch;
    wire c_dav, c_atn, dav_oe, nrfd_oe, ndac_oe, srq_oe, dav_w;
    wire [63:0] latch_data;
    wire [35:0] freq;
    wire remote, talker, listener;
    // Open-drain wires: pulled high unless someone drives low
    assign dio_w = c_dio & ~dio_oe;
    assign dav_w = c_dav & ~dav_oe;
    always #50 mclk = ~mclk;
    gpc_ctl_model i_ctl (.mclk(mclk), .nrfd_n(~nrfd_oe), .ndac_n(~ndac_oe),
        .dio_n(c_dio), .dav_n(c_dav), .atn_n(c_atn));
    gpc_parser i_dut (.mclk(mclk), .resetn(resetn), .dio_n_i(dio_w),
        .dio_n_o(), .dio_n_oe(dio_oe), .dav_n_i(dav_w), .dav_n_o(),
        .dav_n_oe(dav_oe), .nrfd_n_i(~nrfd_oe), .nrfd_n_o(),
        .nrfd_n_oe(nrfd_oe), .ndac_n_i(~ndac_oe), .ndac_n_o(),
        .ndac_n_oe(ndac_oe), .atn_n_i(c_atn), .ifc_n_i(1'b1),
        .ren_n_i(ren_n), .eoi_n_i(1'b1), .srq_n_o(), .srq_n_oe(srq_oe),
        .bus_addr(ADDR), .status_byte(8'h00), .service_req(service_req),
        .panel_settings(PANEL), .latch_data_r(latch_data),
        .latch_strobe_r(), .remote_amplitude_mod_strobe(),
        .remote_frequency_mod_strobe(), .parser_cycle_trigger(),
        .freq_reg1_r(freq), .remote_r(remote), .talker_r(talker),
        .listener_r(listener), .clear_pulse_r());
    task automatic chk(input [63:0] got, input [63:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask
    task automatic send_str(input string s, input bit atn);
        foreach (s[i]) i_ctl.send(s[i], atn);
        settle();
    endtask
    task automatic t_listen();
        ren_n <= 1'b0;
        i_ctl.send({3'h1, ADDR}, 1'b1);
        settle();
        chk(listener, 1);
        chk(remote, 1);
        chk(latch_data, PANEL);
    endtask
    // Abbreviated strings, code reload and frequency digits
    task automatic t_args();
        exp_r = PANEL;
        send_str("M56", 1'b0);
        exp_r[11:8] = 4'h5;
        exp_r[15:12] = 4'h6;
        chk(latch_data, exp_r);
        send_str("K7", 1'b0);
        exp_r[3:0] = 4'h7;
        chk(latch_data, exp_r);
        send_str("P12", 1'b0);
        chk(freq[7:0], 8'h12);
    endtask
    task automatic t_unlisten();
        send_str("?", 1'b1); // Unlisten command
        chk(listener, 0);
        send_str("K9", 1'b0);
        chk(latch_data[15:0], exp_r[15:0]);
    endtask
    task automatic t_poll();
        service_req <= 1'b1;
        i_ctl.send({3'h2, ADDR}, 1'b1);
        settle();
        chk(talker, 1);
        chk(srq_oe, 1);
        i_ctl.send(8'h18, 1'b1); // Serial poll enable
        settle();
        chk(srq_oe, 0);
        i_ctl.send(8'h19, 1'b1); // Serial poll disable
        settle();
        chk(srq_oe, 1);
    endtask
    task automatic t_ren_drop();
        // Enable is still held from the listen scenario; release it only
        ren_n <= 1'b1;
        settle();
        chk(remote, 0);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_listen();
        t_args();
        t_unlisten();
        t_poll();
        t_ren_drop();
        stop_test();
    end
endmodule // tb_gpc_parser
bind gpc_parser gpc_parser_chk i_chk (.mclk(mclk), .resetn(resetn),
    .dav_n_i(dav_n_i), .ren_n_i(ren_n_i), .nrfd_n_oe(nrfd_n_oe),
    .ndac_n_oe(ndac_n_oe), .dio_n_oe(dio_n_oe), .srq_n_oe(srq_n_oe),
    .service_req(service_req), .panel_settings(panel_settings),
    .latch_data_r(latch_data_r), .latch_strobe_r(latch_strobe_r),
    .remote_amplitude_mod_strobe(remote_amplitude_mod_strobe),
    .remote_frequency_mod_strobe(remote_frequency_mod_strobe),
    .remote_r(remote_r), .talker_r(talker_r), .listener_r(listener_r));
